// ---- hdl/fpci_host.sv ----
// Host-side controller that drives an asynchronous parallel flash through its pins.
`timescale 1ns/1ps
// What this block does
// - Byte-wide address width 20, 21, 22 bits.
// - Word-wide address width 19, 20, 21 bits.
// - Program data goes on second write cycle.
// - Commands only on low byte, CE and WE low.
// - Reads keep write strobe and reset high.
module fpci_host
  import fpci_pkg::*;
#(
  parameter int DENSITY_MBIT = 32,
  parameter bit WORD_MODE = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reqValid,
  output logic reqReady,
  input wire fpci_req_s req,
  output logic rdValid,
  output logic [DATA_W-1:0] rdData,
  input wire logic lockDownOn,
  output fpci_pins_s pins,
  output logic wpN,
  output logic [ADDR_MAX-1:0] addressLines,
  output logic [DATA_W-1:0] dataLinesOut,
  output logic [1:0] dataLinesOe,
  input wire logic [DATA_W-1:0] dataLinesIn
);

  // Address width follows density and bus width.
  localparam int ADDR_W = fpciAddrW(DENSITY_MBIT, WORD_MODE);
  // Address bits that this part really has.
  localparam logic [ADDR_MAX-1:0] ADDR_MASK = ADDR_MAX'((64'h1 << ADDR_W) - 64'h1);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // State and storage.
  //////////////////////////////////////////////////////////////////////////////////////////////

  // One-hot phases of a pin transaction.
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_RESET = 7'h02,
    S_RREC = 7'h04,
    S_WSET = 7'h08,
    S_WLOW = 7'h10,
    S_WREC = 7'h20,
    S_RACC = 7'h40
  } fpci_state_e;

  fpci_state_e state_reg, state_next; // Current and next phase.
  fpci_req_s cur_reg, cur_next; // Request being carried out.
  logic second_reg, second_next; // Set on the data cycle of a program.
  fpci_pins_s pins_reg, pins_next; // Strobes toward the flash.
  logic [DATA_W-1:0] dout_reg, dout_next; // Data driven toward the flash.
  logic [1:0] doe_reg, doe_next; // Byte-lane drive enables.
  logic [DATA_W-1:0] rd_reg, rd_next; // Captured read data.
  logic rdv_reg, rdv_next; // One-cycle read answer.
  logic wp_reg; // Write-protect level.
  logic boot_reg; // First cycle after reset; starts the timed reset pulse.
  logic [DATA_W-1:0] sync1_reg, sync2_reg; // Data input synchroniser.
  logic tload; // Start of a timed phase.
  logic [TIMER_W-1:0] tval; // Length of that phase.
  logic tdone; // Current phase has run its length.

  // Decoded request qualities.
  wire take = reqValid && reqReady;
  wire isProg = (cur_reg.op == OP_PROGRAM);
  // Upper lane is driven only for array data on word-wide parts.
  wire [1:0] dataLanes = WORD_MODE ? 2'h3 : 2'h1;
  wire [ADDR_MAX-1:0] reqAddr = req.addr & ADDR_MASK;

  assign reqReady = (state_reg == S_IDLE);
  assign pins = pins_reg;
  assign wpN = wp_reg;
  assign addressLines = cur_reg.addr;
  assign dataLinesOut = dout_reg;
  assign dataLinesOe = doe_reg;
  assign rdData = rd_reg;
  assign rdValid = rdv_reg;

  // Phase timer shared by all phases.
  fpci_timer #(
    .W(TIMER_W)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .load(tload),
    .loadVal(tval),
    .done(tdone)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Phase sequencing.
  //////////////////////////////////////////////////////////////////////////////////////////////

  // Each branch names the strobes of the phase it enters, so pins stay glitch free.
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    second_next = second_reg;
    pins_next = pins_reg;
    dout_next = dout_reg;
    doe_next = doe_reg;
    rd_next = rd_reg;
    rdv_next = 1'b0;
    tload = 1'b0;
    tval = TIMER_W'(1);
    case (state_reg)
      S_IDLE: begin
        // Between requests the device is deselected and the bus is released.
        if (take) begin
          cur_next = req;
          cur_next.addr = reqAddr;
          second_next = 1'b0;
          tload = 1'b1;
          if (req.op == OP_RESET) begin
            state_next = S_RESET;
            pins_next = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, rpN: 1'b0};
            tval = TIMER_W'(RESET_LOW_CYC);
          end else if (req.op == OP_READ) begin
            // Write strobe and reset stay high for every read.
            state_next = S_RACC;
            pins_next = '{ceN: 1'b0, oeN: 1'b0, weN: 1'b1, rpN: 1'b1};
            tval = TIMER_W'(READ_ACC_CYC);
          end else begin
            // Command byte first, on the low lane only.
            state_next = S_WSET;
            pins_next = '{ceN: 1'b0, oeN: 1'b1, weN: 1'b1, rpN: 1'b1};
            dout_next = {{(DATA_W-CMD_W){1'b0}}, req.cmd};
            doe_next = 2'h1;
            tval = TIMER_W'(SETUP_CYC);
          end
        end
      end
      S_RESET: begin
        // The timer leaves reset empty, so the first pulse is timed on entry.
        if (boot_reg) begin
          tload = 1'b1;
          tval = TIMER_W'(RESET_LOW_CYC);
        end else if (tdone) begin
          // Releasing reset returns the device to read-array with no command.
          state_next = S_RREC;
          pins_next.rpN = 1'b1;
          tload = 1'b1;
          tval = TIMER_W'(RESET_REC_CYC);
        end
      end
      S_RREC: begin
        if (tdone) begin
          state_next = S_IDLE;
        end
      end
      S_WSET: begin
        // Address and data settle before the strobe falls; output enable stays high.
        if (tdone) begin
          state_next = S_WLOW;
          pins_next.weN = 1'b0;
          tload = 1'b1;
          tval = TIMER_W'(WE_LOW_CYC);
        end
      end
      S_WLOW: begin
        // The device latches on the rising strobe, so data is still driven here.
        if (tdone) begin
          state_next = S_WREC;
          pins_next.weN = 1'b1;
          tload = 1'b1;
          tval = TIMER_W'(WE_REC_CYC);
        end
      end
      S_WREC: begin
        if (tdone) begin
          tload = 1'b1;
          if (isProg && !second_reg) begin
            // Second cycle of a program carries the array data.
            state_next = S_WSET;
            second_next = 1'b1;
            dout_next = cur_reg.data;
            doe_next = dataLanes;
            tval = TIMER_W'(SETUP_CYC);
          end else begin
            // Deselecting is safe even if the device is still busy programming.
            state_next = S_RREC;
            pins_next.ceN = 1'b1;
            doe_next = 2'h0;
            tval = TIMER_W'(READ_REL_CYC);
          end
        end
      end
      S_RACC: begin
        // Sample after access time plus the synchroniser depth.
        if (tdone) begin
          state_next = S_RREC;
          pins_next.oeN = 1'b1;
          pins_next.ceN = 1'b1;
          rd_next = WORD_MODE ? sync2_reg : {8'h00, sync2_reg[7:0]};
          rdv_next = 1'b1;
          tload = 1'b1;
          // The device needs time to float its outputs before the next drive.
          tval = TIMER_W'(READ_REL_CYC);
        end
      end
      default: begin
        state_next = S_IDLE;
        pins_next = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, rpN: 1'b1};
        doe_next = 2'h0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registers.
  //////////////////////////////////////////////////////////////////////////////////////////////

  // After reset the flash is held in reset and released through the normal phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_RESET;
      cur_reg <= '0;
      second_reg <= 1'b0;
      pins_reg <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, rpN: 1'b0};
      dout_reg <= '0;
      doe_reg <= 2'h0;
      rd_reg <= '0;
      rdv_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else if (ce) begin
      boot_reg <= 1'b0;
      state_reg <= state_next;
      cur_reg <= cur_next;
      second_reg <= second_next;
      pins_reg <= pins_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
      rd_reg <= rd_next;
      rdv_reg <= rdv_next;
    end
  end

  // Write protect follows the user level; low enforces lock-down.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_reg <= 1'b0;
    end else if (ce) begin
      wp_reg <= !lockDownOn;
    end
  end

  // Flash data arrives unclocked, so it passes two flip-flops first.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (ce) begin
      sync1_reg <= dataLinesIn;
      sync2_reg <= sync1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.
  //////////////////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles that the reset pin has been low.
  logic [TIMER_W:0] rpLowCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rpLowCnt <= '0;
    end else begin
      rpLowCnt <= pins_reg.rpN ? '0 : rpLowCnt + (TIMER_W+1)'(1);
    end
  end

  a_oe_we_excl: assert property (!(!pins_reg.oeN && !pins_reg.weN))
    else $error("Output enable and write strobe low together.");
  a_read_we_rp: assert property (!pins_reg.oeN |-> pins_reg.weN && pins_reg.rpN)
    else $error("Read without write strobe and reset high.");
  a_read_no_drive: assert property (!pins_reg.oeN |-> doe_reg == 2'h0)
    else $error("Host drives data while the flash may drive.");
  a_cmd_strobe_ce: assert property (!pins_reg.weN |-> !pins_reg.ceN && doe_reg[0])
    else $error("Write strobe without select or data.");
  a_data_past_rise: assert property ($rose(pins_reg.weN) |-> doe_reg[0] &&
      $stable(dout_reg) && $stable(cur_reg.addr))
    else $error("Data or address moved at the write strobe rise.");
  a_reset_width: assert property ($rose(pins_reg.rpN) |-> rpLowCnt >= RESET_LOW_CYC)
    else $error("Reset pulse shorter than its least time.");
  a_release_gap: assert property ($rose(pins_reg.oeN) |-> doe_reg == 2'h0 [*2])
    else $error("Bus driven too soon after a read.");
  a_prog_data: assert property (ce && state_reg == S_WREC && tdone && isProg && !second_reg
      |=> doe_reg == dataLanes && dout_reg == cur_reg.data)
    else $error("Program data cycle not presented.");
  a_addr_range: assert property ((cur_reg.addr & ~ADDR_MASK) == '0)
    else $error("Address beyond the part's width.");

endmodule

// ---- hdl/fpci_pkg.sv ----
// Shared constants, types and helpers for the parallel flash pin controller.
package fpci_pkg;

  // Clock period of the controller in nanoseconds.
  localparam int CLK_NS = 4;
  // Widest address bus over all densities and bus widths.
  localparam int ADDR_MAX = 22;
  // Full data bus width; the upper byte exists on word-wide parts only.
  localparam int DATA_W = 16;
  // Command codes travel on the low byte only.
  localparam int CMD_W = 8;
  // Width of the phase timer counter.
  localparam int TIMER_W = 8;
  // Depth of the data-input synchroniser.
  localparam int SYNC_STAGES = 2;

  // Pin phase times in nanoseconds, as least times.
  localparam int SETUP_NS = 20;
  localparam int WE_LOW_NS = 60;
  localparam int WE_REC_NS = 30;
  localparam int READ_ACC_NS = 100;
  localparam int READ_REL_NS = 30;
  localparam int RESET_LOW_NS = 150;
  localparam int RESET_REC_NS = 200;

  // Least times round up to whole cycles, never below one.
  function automatic int fpciCycles(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SETUP_CYC = fpciCycles(SETUP_NS);
  localparam int WE_LOW_CYC = fpciCycles(WE_LOW_NS);
  localparam int WE_REC_CYC = fpciCycles(WE_REC_NS);
  localparam int READ_ACC_CYC = fpciCycles(READ_ACC_NS) + SYNC_STAGES;
  localparam int READ_REL_CYC = fpciCycles(READ_REL_NS);
  localparam int RESET_LOW_CYC = fpciCycles(RESET_LOW_NS);
  localparam int RESET_REC_CYC = fpciCycles(RESET_REC_NS);

  // Address width for a density in megabits and a bus width.
  function automatic int fpciAddrW(input int densityMbit, input bit wordMode);
    int w;
    w = (densityMbit >= 32) ? 22 : (densityMbit >= 16) ? 21 : 20;
    return wordMode ? w - 1 : w;
  endfunction

  // Operations the user side may request.
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_COMMAND = 2'h1,
    OP_PROGRAM = 2'h2,
    OP_RESET = 2'h3
  } fpci_op_e;

  // One request from the user side.
  typedef struct packed {
    fpci_op_e op;
    logic [ADDR_MAX-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CMD_W-1:0] cmd;
  } fpci_req_s;

  // Control strobes toward the flash, all active low.
  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic rpN;
  } fpci_pins_s;

endpackage

// ---- hdl/fpci_timer.sv ----
// Down counter that times each pin phase of the flash controller.
`timescale 1ns/1ps
module fpci_timer
  import fpci_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic done
);

  // Remaining cycles of the current phase.
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // A load of N keeps done low for N-1 cycles, so a phase lasts N cycles.
  assign cnt_next = load ? loadVal - W'(1) : (cnt_reg != '0 ? cnt_reg - W'(1) : cnt_reg);
  assign done = (cnt_reg == '0);

  // The counter freezes while the clock enable is low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// ---- verification/fpci_flash_model.sv ----
// Behavioural model of the parallel flash part as seen at its pins.
`timescale 1ns/1ps
module fpci_flash_model
  import fpci_pkg::*;
#(
  parameter logic [7:0] PROG_CODE = 8'h40
) (
  input wire fpci_pins_s pins,
  input wire logic wpN,
  input wire logic [ADDR_MAX-1:0] addressLines,
  input wire logic [DATA_W-1:0] dataLinesOut,
  input wire logic [1:0] dataLinesOe,
  output logic [DATA_W-1:0] dataLinesIn,
  output logic [CMD_W-1:0] lastCmd,
  output int resetCount
);
  // Words written so far; an unwritten word reads as its inverted address.
  logic [DATA_W-1:0] mem [int];
  // Set by the program command until the data cycle arrives.
  logic progPending = 1'b0;
  // Every block is locked after a reset.
  logic blocksLocked = 1'b1;
  // Last word driven, kept so released lines can show its inverse.
  logic [DATA_W-1:0] lastOut = 16'h0000;
  logic [DATA_W-1:0] readWord;
  logic [DATA_W-1:0] busIn;
  // The part drives only when selected, enabled and out of reset.
  wire drive = !pins.ceN && !pins.oeN && pins.rpN;
  // Lock-down is enforced while the protect pin is low.
  wire lockDownActive = (wpN === 1'b0);

  ////////////////////////////////////////////////////////////////////////
  // Released lines float, so they show the inverse of the last word.
  always @* begin
    readWord = mem.exists(int'(addressLines)) ? mem[int'(addressLines)] : ~addressLines[15:0];
    dataLinesIn = drive ? readWord : ~lastOut;
    busIn = {dataLinesOe[1] ? dataLinesOut[15:8] : 8'h00, dataLinesOe[0] ? dataLinesOut[7:0] : 8'h00};
  end

  // Remember the driven word when the part lets go of the bus.
  always @(negedge drive) lastOut = readWord;

  ////////////////////////////////////////////////////////////////////////
  // Address and data are taken at the rising write strobe.
  always @(posedge pins.weN) begin
    if (!pins.ceN && pins.rpN) begin
      if (progPending) begin
        // Stored at once, so a later deselect cannot cut the program short.
        mem[int'(addressLines)] = busIn;
        progPending = 1'b0;
      end else begin
        lastCmd = busIn[7:0];
        progPending = (busIn[7:0] == PROG_CODE);
      end
    end
  end

  // The reset pin clears any half-done write and counts the pulse.
  always @(negedge pins.rpN) begin
    progPending = 1'b0;
    resetCount = resetCount + 1;
  end

  // Leaving reset locks every block and returns to array reads.
  always @(posedge pins.rpN) blocksLocked = 1'b1;
endmodule

// ---- verification/fpci_host_tb_top.sv ----
// Self-checking testbench of the flash pin controller with a flash model.
`timescale 1ns/1ps
module fpci_host_tb_top
  import fpci_pkg::*;
;
  localparam logic [7:0] PROG_CODE = 8'h40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic ceRun = 1'b0;
  logic reqValid = 1'b0;
  logic reqReady, rdValid, wpN, lockDownOn = 1'b0;
  fpci_req_s req = '0;
  logic [DATA_W-1:0] rdData, dataLinesOut, dataLinesIn;
  logic [ADDR_MAX-1:0] addressLines, seenAddr, a;
  logic [1:0] dataLinesOe;
  logic [CMD_W-1:0] lastCmd, c;
  logic [15:0] d;
  fpci_pins_s pins;
  int resetCount, failures = 0, checksDone = 0, cycles = 0, badLink = 0, seed, r;

  fpci_host dut (.clk(clk), .rst(rst), .ce(ce), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rdValid(rdValid), .rdData(rdData), .lockDownOn(lockDownOn), .pins(pins),
    .wpN(wpN), .addressLines(addressLines), .dataLinesOut(dataLinesOut),
    .dataLinesOe(dataLinesOe), .dataLinesIn(dataLinesIn));
  fpci_flash_model #(.PROG_CODE(PROG_CODE)) flash (.pins(pins), .wpN(wpN),
    .addressLines(addressLines), .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe),
    .dataLinesIn(dataLinesIn), .lastCmd(lastCmd), .resetCount(resetCount));

  ////////////////////////////////////////////////////////////////////////
  // Clock, random clock-enable stalls, watchdog and pin monitors.
  always #2 clk = ~clk;
  always @(posedge clk) ce <= ceRun ? ($urandom % 4 != 0) : 1'b1;
  // A hang is cut short well past the expected run of under two thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // Reads must keep write strobe and reset high; strobes never overlap.
  always @(negedge clk) begin
    if (!rst && !pins.oeN && (!pins.weN || !pins.rpN)) badLink++;
    if (pins.ceN === 1'b0) seenAddr <= addressLines;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address mask the part of a density and width is expected to see.
  function automatic logic [21:0] partMask(input int mbit, input bit word);
    int w;
    w = (mbit >= 32) ? 22 : (mbit >= 16) ? 21 : 20;
    if (word) w--;
    return (22'h1 << w) - 22'h1;
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Waits, bounded, until the controller can take a request.
  task automatic waitIdle();
    int n;
    n = 0;
    do @(negedge clk); while (!(ce && reqReady) && ++n < 600);
    if (n >= 600) failures++;
  endtask

  // Offers one request and holds it until the taking edge.
  task automatic doReq(input fpci_op_e op, input logic [21:0] ad, input logic [15:0] dt,
                       input logic [7:0] cm);
    @(posedge clk);
    req <= '{op: op, addr: ad, data: dt, cmd: cm};
    reqValid <= 1'b1;
    waitIdle();
    @(posedge clk);
    reqValid <= 1'b0;
  endtask

  // Reads one word and compares data and the address seen on the pins.
  task automatic readCheck(input logic [21:0] ad, input logic [15:0] exp);
    int n;
    n = 0;
    doReq(OP_READ, ad, 16'h0000, 8'h00);
    do @(negedge clk); while (rdValid !== 1'b1 && ++n < 400);
    if (n >= 400) failures++;
    check(rdData, exp);
    check(seenAddr, ad & partMask(32, 1'b1));
  endtask

  // Ends the run with the counts and the verdict.
  task automatic complete_run();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = $urandom(32'h8cdd);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    ceRun <= 1'b1;
    // Program then read back, top address first, then random ones.
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 22'h3fffff : 22'($urandom);
      d = 16'($urandom);
      doReq(OP_PROGRAM, a, d, PROG_CODE);
      readCheck(a, d);
    end
    $display("test program and read done");
    // An unwritten word reads as its inverted address in array mode.
    readCheck(22'h000123, 16'hfedc);
    $display("test unwritten read done");
    // Plain commands reach the part on the low byte.
    for (int i = 0; i < 4; i++) begin
      c = 8'($urandom) | 8'h01;
      doReq(OP_COMMAND, 22'($urandom), 16'($urandom), c);
      waitIdle();
      check(lastCmd, c);
    end
    $display("test commands done");
    // A reset pulse after a lone program command drops the pending write.
    doReq(OP_COMMAND, 22'h000040, 16'h0000, PROG_CODE);
    r = resetCount;
    doReq(OP_RESET, 22'h0, 16'h0, 8'h00);
    waitIdle();
    check(resetCount, r + 1);
    a = 22'h000200;
    doReq(OP_COMMAND, a, 16'h0000, 8'h77);
    readCheck(a, ~a[15:0]);
    $display("test reset done");
    // Protect pin follows the lock-down request in both directions.
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      lockDownOn <= v[0];
      repeat (8) @(negedge clk);
      check(wpN, !v[0]);
    end
    $display("test protect done");
    check(badLink, 0);
    complete_run();
  end
endmodule
